//--- logic/amc_pkg.sv
// constants and carriers for the converter mode and oversample control
// assumes a single 250 MHz clock domain
package amc_pkg;
    // clock period and timing figures
    localparam int CLK_NS = 4;
    localparam int SETUP_US = 253;
    localparam int PART_MIN_NS = 50;
    localparam int PART_MAX_NS = 2000;
    localparam int FULL_MIN_NS = 3000;
    localparam int CONV_NS = 1250;
    localparam int SETUP_CYC = (SETUP_US * 1000) / CLK_NS;
    localparam int PART_MIN_CYC = (PART_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int FULL_MIN_CYC = (FULL_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    // oversample codes
    localparam logic [2:0] OS_SOFT = 3'h7;
    localparam logic [3:0] OSR_MAX_SW = 4'h8;
    // register addresses and frame fields
    localparam logic [6:0] ADDR_CFG = 7'h02;
    localparam logic [6:0] ADDR_RANGE_LO = 7'h03;
    localparam logic [6:0] ADDR_RANGE_HI = 7'h04;
    localparam logic [6:0] ADDR_COMP = 7'h05;
    localparam logic [6:0] ADDR_DISC = 7'h06;
    localparam logic [6:0] ADDR_DIAG = 7'h07;
    localparam int FRAME_BITS = 16;
    localparam int RW_BIT = 15;
    // field reset values and fixed hardware settings
    localparam logic [1:0] DOUT_ONE = 2'h0;
    localparam logic [1:0] DOUT_TWO = 2'h1;
    localparam logic [1:0] DOUT_FOUR = 2'h2;
    localparam logic [1:0] RANGE_10V = 2'h2;
    localparam logic [15:0] RANGE_RST = 16'hAAAA;
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W = 16;
    // active configuration handed to the analog core
    typedef struct packed {
        logic [3:0] osr_code;
        logic [1:0] dout_lines;
        logic [15:0] ranges;
        logic [7:0] comp_en;
        logic [7:0] disc_en;
        logic diag_en;
    } amc_cfg_type;
    // conversion results of all eight channels
    typedef logic [7:0][WORD_W-1:0] amc_codes_type;
endpackage

//--- logic/amc_fifo.sv
// flip-flop fifo with valid and ready on both sides
// assumes synchronous use on one clock with active low async reset
`timescale 1ns/1ns
`default_nettype none
module amc_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic flush,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_ff [D]; // storage words
    logic [AW-1:0] wr_ff; // write index
    logic [AW-1:0] rd_ff; // read index
    logic [AW:0] cnt_ff; // fill level
    logic push;
    logic pop;
    assign in_ready = (cnt_ff != (AW+1)'(D)) && !flush;
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready && !flush;
    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
    // indices and level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else if (flush) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
            if (pop) rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

//--- logic/amc_ctrl.sv
// mode selection, oversample decode, register access and conversion sequencing
// assumes pins are asynchronous to clk; analog core supplies channel codes
`timescale 1ns/1ns
`default_nettype none
module amc_ctrl
    import amc_pkg::*;
#(
    parameter int SETUP_CYCLES = amc_pkg::SETUP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // mode pins
    input wire logic oversample_select_bit0,
    input wire logic oversample_select_bit1,
    input wire logic oversample_select_bit2,
    input wire logic interface_choice_input,
    input wire logic reset_pin,
    // register access pins
    input wire logic serial_config_input,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic [15:0] parallel_bus_lines,
    // conversion
    input wire logic conversion_trigger,
    input wire amc_pkg::amc_codes_type adc_codes,
    // configuration and status
    output amc_pkg::amc_cfg_type active_cfg,
    output logic soft_mode,
    output logic serial_mode,
    output logic setup_done,
    output logic busy,
    output logic [7:0] read_data,
    output logic read_valid,
    // result stream
    output logic res_valid,
    input wire logic res_ready,
    output logic [15:0] res_data
);
    import amc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_PUSH = 2'b10
    } amc_state_type;

    // conversions per trigger for an oversample code
    function automatic logic [8:0] osr_count(input logic [3:0] code);
        osr_count = 9'h001 << code;
    endfunction

    logic [25:0] s1_ff; // first synchroniser stage
    logic [25:0] s2_ff; // second synchroniser stage
    logic [9:0] d_ff; // previous synchronised value
    logic [2:0] os_pins;
    logic rst_in;
    logic trig_rise;
    logic sclk_rise;
    logic wr_rise;
    logic rst_fall;
    logic part_rst;
    logic full_rst;
    logic [9:0] rw_cnt_ff; // reset pin high width
    logic [2:0] init_ff; // shifts out while the pins sync
    logic [2:0] os_lat_ff; // latched select pins
    logic [16:0] setup_cnt_ff; // setup wait remaining
    logic [15:0] shift_ff; // serial frame shifter
    logic [4:0] bit_cnt_ff; // serial bits received
    logic wr_en;
    logic [15:0] wr_word;
    logic [3:0] osr_reg_ff; // software ratio code
    logic [1:0] dout_reg_ff; // software output lines
    logic [15:0] range_ff; // per channel ranges
    logic [7:0] comp_ff; // compensation enables
    logic [7:0] disc_ff; // disconnect enables
    logic diag_ff; // diagnostics enable
    logic [7:0] rd_mux;
    amc_state_type st_ff;
    logic [8:0] left_ff; // conversions remaining
    logic [8:0] cyc_ff; // cycles in conversion
    logic [2:0] ch_ff; // channel being pushed
    amc_codes_type codes_ff; // captured results
    logic fifo_ready;

    // two flop synchronisers on every pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_ff <= 26'h00000C0;  // strobe and select rest high
            s2_ff <= 26'h00000C0;
            d_ff <= 10'h0C0;
        end else begin
            s1_ff <= {parallel_bus_lines, reset_pin, conversion_trigger, write_strobe_n,
                      chip_select_n, serial_clock, serial_config_input, interface_choice_input,
                      oversample_select_bit2, oversample_select_bit1, oversample_select_bit0};
            s2_ff <= s1_ff;
            d_ff <= s2_ff[9:0];
        end
    end

    assign os_pins = s2_ff[2:0];
    assign rst_in = s2_ff[9];
    assign trig_rise = s2_ff[8] && !d_ff[8];
    assign wr_rise = s2_ff[7] && !d_ff[7];
    assign sclk_rise = s2_ff[5] && !d_ff[5];
    assign rst_fall = !rst_in && d_ff[9];
    // width decides the kind of reset; between the windows it acts partial
    assign full_rst = rst_fall && (rw_cnt_ff >= 10'(FULL_MIN_CYC));
    assign part_rst = rst_fall && !full_rst
                      && (rw_cnt_ff >= 10'(PART_MIN_CYC));

    // reset pin width counter, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rw_cnt_ff <= 10'h000;
        end else if (!rst_in) begin
            rw_cnt_ff <= 10'h000;
        end else if (rw_cnt_ff != 10'(FULL_MIN_CYC)) begin
            rw_cnt_ff <= rw_cnt_ff + 10'h001;
        end
    end

    // select pins caught after power-up and at each reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            init_ff <= 3'h7;
            os_lat_ff <= 3'h0;
        end else begin
            init_ff <= {init_ff[1:0], 1'b0};
            if (init_ff[2] || full_rst || part_rst) begin
                os_lat_ff <= os_pins;
            end
        end
    end

    assign soft_mode = (os_lat_ff == OS_SOFT);
    assign serial_mode = s2_ff[3];
    assign setup_done = (setup_cnt_ff == 17'h00000);

    // setup wait after power-up, full and partial reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            setup_cnt_ff <= 17'h1FFFF;
        end else if (init_ff[2] || full_rst) begin
            setup_cnt_ff <= 17'(SETUP_CYCLES);
        end else if (part_rst) begin
            setup_cnt_ff <= 17'(PART_MIN_CYC);
        end else if (!setup_done) begin
            setup_cnt_ff <= setup_cnt_ff - 17'h00001;
        end
    end

    // serial frame receiver, active only in software serial mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_ff <= 16'h0000;
            bit_cnt_ff <= 5'h00;
        end else if (s2_ff[6] || !soft_mode || !serial_mode) begin
            bit_cnt_ff <= 5'h00;  // frame aborted by deselect
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[14:0], s2_ff[4]};
            bit_cnt_ff <= (bit_cnt_ff == 5'(FRAME_BITS)) ? 5'h01 : bit_cnt_ff + 5'h01;
        end
    end

    // write source: serial frame or parallel strobe
    always_comb begin
        wr_en = 1'b0;
        wr_word = s2_ff[25:10];
        if (soft_mode && serial_mode) begin
            wr_word = shift_ff;
            // taken once, at the clock fall ending bit sixteen
            wr_en = (bit_cnt_ff == 5'(FRAME_BITS)) && !s2_ff[5]
                    && d_ff[5] && !shift_ff[RW_BIT];
        end else if (soft_mode && !serial_mode) begin
            // a strobe moving with the trigger is a tied pin, not a write
            wr_en = wr_rise && !s2_ff[6] && !trig_rise;
        end
    end

    // configuration registers, software mode only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osr_reg_ff <= 4'h0;
            dout_reg_ff <= DOUT_ONE;
            range_ff <= RANGE_RST;
            comp_ff <= 8'h00;
            disc_ff <= 8'h00;
            diag_ff <= 1'b0;
        end else if (init_ff[2] || full_rst) begin
            osr_reg_ff <= 4'h0;
            dout_reg_ff <= DOUT_ONE;
            range_ff <= RANGE_RST;
            comp_ff <= 8'h00;
            disc_ff <= 8'h00;
            diag_ff <= 1'b0;
        end else if (wr_en) begin
            unique case (wr_word[14:8])
                ADDR_CFG: begin
                    // ratios above 256 clamp to 256
                    osr_reg_ff <= (wr_word[3:0] > OSR_MAX_SW) ? OSR_MAX_SW
                                  : wr_word[3:0];
                    dout_reg_ff <= (wr_word[5:4] == 2'h3) ? DOUT_FOUR
                                   : wr_word[5:4];
                end
                ADDR_RANGE_LO: range_ff[7:0] <= wr_word[7:0];
                ADDR_RANGE_HI: range_ff[15:8] <= wr_word[7:0];
                ADDR_COMP: comp_ff <= wr_word[7:0];
                ADDR_DISC: disc_ff <= wr_word[7:0];
                ADDR_DIAG: diag_ff <= wr_word[0];
                default: begin
                    // unmapped address, write dropped
                end
            endcase
        end
    end

    // read value for a serial read frame
    always_comb begin
        unique case (shift_ff[14:8])
            ADDR_CFG: rd_mux = {2'h0, dout_reg_ff, osr_reg_ff};
            ADDR_RANGE_LO: rd_mux = range_ff[7:0];
            ADDR_RANGE_HI: rd_mux = range_ff[15:8];
            ADDR_COMP: rd_mux = comp_ff;
            ADDR_DISC: rd_mux = disc_ff;
            ADDR_DIAG: rd_mux = {7'h00, diag_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // read answer, one pulse per completed read frame
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            read_data <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= 1'b0;
            if (soft_mode && serial_mode && bit_cnt_ff == 5'(FRAME_BITS)
                && !s2_ff[5] && d_ff[5] && shift_ff[RW_BIT]) begin
                read_data <= rd_mux;
                read_valid <= 1'b1;
            end
        end
    end

    // active configuration: hardware mode hides software features
    always_comb begin
        if (soft_mode) begin
            active_cfg.osr_code = osr_reg_ff;
            active_cfg.dout_lines = dout_reg_ff;
            active_cfg.ranges = range_ff;
            active_cfg.comp_en = comp_ff;
            active_cfg.disc_en = disc_ff;
            active_cfg.diag_en = diag_ff;
        end else begin
            active_cfg.osr_code = {1'b0, os_lat_ff};
            active_cfg.dout_lines = DOUT_TWO;
            active_cfg.ranges = RANGE_RST;
            active_cfg.comp_en = 8'h00;
            active_cfg.disc_en = 8'h00;
            active_cfg.diag_en = 1'b0;
        end
    end

    assign busy = (st_ff != ST_IDLE);

    // conversion sequencer: trigger, oversampled conversions, push
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= ST_IDLE;
            left_ff <= 9'h000;
            cyc_ff <= 9'h000;
            ch_ff <= 3'h0;
            codes_ff <= '0;
        end else if (full_rst || part_rst) begin
            st_ff <= ST_IDLE;
            ch_ff <= 3'h0;
        end else begin
            unique case (st_ff)
                ST_IDLE: begin
                    // triggers before setup or while busy are ignored
                    if (trig_rise && setup_done) begin
                        st_ff <= ST_CONV;
                        left_ff <= osr_count(active_cfg.osr_code);
                        cyc_ff <= 9'h000;
                    end
                end
                ST_CONV: begin
                    // one conversion every 1.25 us gives 800 kSPS
                    if (cyc_ff == 9'(CONV_CYC - 1)) begin
                        cyc_ff <= 9'h000;
                        left_ff <= left_ff - 9'h001;
                        if (left_ff == 9'h001) begin
                            codes_ff <= adc_codes;
                            ch_ff <= 3'h0;
                            st_ff <= ST_PUSH;
                        end
                    end else begin
                        cyc_ff <= cyc_ff + 9'h001;
                    end
                end
                ST_PUSH: begin
                    // fifo back-pressure stalls the push
                    if (fifo_ready) begin
                        ch_ff <= ch_ff + 3'h1;
                        if (ch_ff == 3'h7) st_ff <= ST_IDLE;
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // result buffer between sequencer and data interface
    amc_fifo #(
        .W(WORD_W),
        .D(FIFO_DEPTH)
    ) i_amc_fifo (
        .clk(clk),
        .nrst(nrst),
        .flush(full_rst || part_rst),
        .in_valid(st_ff == ST_PUSH),
        .in_ready(fifo_ready),
        .in_data(codes_ff[ch_ff]),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
endmodule
`default_nettype wire

//--- verif/amc_ctrl_checker.sv
// port checks for the mode and oversample control
// assumes one clock domain; bound to amc_ctrl below
`timescale 1ns/1ns
`default_nettype none
module amc_ctrl_checker #(
    parameter int SETUP_CYCLES = 200
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins
    input wire logic interface_choice_input,
    input wire logic reset_pin,
    input wire logic chip_select_n,
    input wire logic conversion_trigger,
    // outputs
    input wire amc_pkg::amc_cfg_type active_cfg,
    input wire logic soft_mode,
    input wire logic serial_mode,
    input wire logic setup_done,
    input wire logic busy,
    input wire logic read_valid
);
    import amc_pkg::*;
    int quiet; // cycles since any reset
    int por; // cycles since power-up
    int bcnt; // cycles of the current conversion
    // distance from the last reset of either kind
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) quiet <= 0;
        else if (reset_pin) quiet <= 0;
        else if (quiet < 99) quiet <= quiet + 1;
    end
    // distance from power-up, stops just past the setup wait
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) por <= 0;
        else if (por < SETUP_CYCLES + 9) por <= por + 1;
    end
    // length of the busy run
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) bcnt <= 0;
        else bcnt <= busy ? bcnt + 1 : 0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    pin_hold_a: assert property (
        quiet > 20 |-> $stable(soft_mode) && (soft_mode || $stable(active_cfg.osr_code)))
        else $error("mode or ratio moved without reset");
    hw_fixed_a: assert property (
        !soft_mode |-> active_cfg.dout_lines == DOUT_TWO && active_cfg.ranges == RANGE_RST
        && active_cfg.comp_en == 8'h00 && active_cfg.disc_en == 8'h00 && !active_cfg.diag_en)
        else $error("software feature active in hardware mode");
    port_sel_a: assert property (
        (nrst && $stable(interface_choice_input))[*5] |-> serial_mode == interface_choice_input)
        else $error("interface choice not followed");
    setup_gap_a: assert property (setup_done |-> por >= SETUP_CYCLES)
        else $error("setup ended early");
    setup_end_a: assert property (por == SETUP_CYCLES + 8 |-> setup_done)
        else $error("setup never ended");
    trig_go_a: assert property (
        setup_done && !busy && $rose(conversion_trigger) |-> ##[2:6] busy)
        else $error("trigger not taken");
    conv_span_a: assert property (
        busy |-> bcnt <= (CONV_CYC << active_cfg.osr_code) + 40)
        else $error("conversion too long");
    conv_min_a: assert property (
        $fell(busy) |-> bcnt >= (CONV_CYC << active_cfg.osr_code))
        else $error("conversion shorter than ratio");
    read_pulse_a: assert property (
        read_valid |-> soft_mode && serial_mode ##1 !read_valid)
        else $error("bad read answer");
    cfg_quiet_a: assert property (
        (soft_mode && chip_select_n && quiet > 20)[*8] |-> $stable(active_cfg))
        else $error("config moved without access");
endmodule
bind amc_ctrl amc_ctrl_checker #(.SETUP_CYCLES(SETUP_CYCLES)) i_amc_ctrl_checker (
    .clk, .nrst, .interface_choice_input, .reset_pin, .chip_select_n, .conversion_trigger,
    .active_cfg, .soft_mode, .serial_mode, .setup_done, .busy, .read_valid
);
`default_nettype wire

//--- verif/amc_host_model.sv
// host controller model: register frames, write strobe, trigger, result reads
// assumes each task is entered just after a falling clock edge
`timescale 1ns/1ns
`default_nettype none
module amc_host_model (
    // clock
    input wire logic clk,
    // access pins
    output logic serial_config_input,
    output logic serial_clock,
    output logic chip_select_n,
    output logic write_strobe_n,
    output logic [15:0] parallel_bus_lines,
    output logic conversion_trigger,
    // answers
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic res_valid,
    input wire logic [15:0] res_data,
    output logic res_ready
);
    // idle levels; serial clock stands still outside frames
    initial begin
        serial_config_input = 1'b1;
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        parallel_bus_lines = 16'hFFFF;
        conversion_trigger = 1'b0;
        res_ready = 1'b0;
    end
    // one serial frame, catching any read answer during the hold
    task automatic frame(input logic [15:0] w, output logic got, output logic [7:0] rd);
        got = 1'b0;
        rd = 8'h00;
        chip_select_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_config_input = w[i]; // msb first
            repeat (3) @(negedge clk);
            serial_clock = 1'b1;
            repeat (3) @(negedge clk);
            serial_clock = 1'b0;
        end
        repeat (12) begin
            @(negedge clk);
            if (read_valid === 1'b1) begin
                got = 1'b1;
                rd = read_data;
            end
        end
        chip_select_n = 1'b1;
        serial_config_input = ~serial_config_input; // released line shows no old value
        @(negedge clk);
    endtask
    // parallel write; tie makes the trigger follow the strobe
    task automatic pwrite(input logic [15:0] w, input logic tie);
        chip_select_n = 1'b0;
        parallel_bus_lines = w;
        write_strobe_n = 1'b0;
        if (tie) conversion_trigger = 1'b0;
        repeat (4) @(negedge clk);
        write_strobe_n = 1'b1; // write on the rising strobe
        if (tie) conversion_trigger = 1'b1;
        repeat (4) @(negedge clk);
        chip_select_n = 1'b1;
        parallel_bus_lines = ~w;
        @(negedge clk);
    endtask
    // one trigger pulse for all channels
    task automatic trig;
        conversion_trigger = 1'b0;
        repeat (4) @(negedge clk);
        conversion_trigger = 1'b1;
        repeat (4) @(negedge clk);
        conversion_trigger = 1'b0;
    endtask
    // take one result word after a short stall
    task automatic take(output logic [15:0] d, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        d = 16'h0000;
        repeat (2) @(negedge clk);
        res_ready = 1'b1;
        while (!ok && n < 50) begin
            if (res_valid === 1'b1) begin
                ok = 1'b1;
                d = res_data;
            end
            @(negedge clk);
            n++;
        end
        res_ready = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/amc_ctrl_test.sv
// self-checking bench for the mode and oversample control
// assumes the host model drives all access pins and the result ready
`timescale 1ns/1ns
`default_nettype none
module amc_ctrl_test;
    import amc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] os = 3'h3; // select pins
    logic interface_choice_input = 1'b0;
    logic reset_pin = 1'b0;
    logic serial_config_input, serial_clock, chip_select_n, write_strobe_n;
    logic conversion_trigger, soft_mode, serial_mode, setup_done, busy;
    logic read_valid, res_valid, res_ready, got;
    logic [15:0] parallel_bus_lines, res_data;
    logic [7:0] read_data, rd;
    amc_codes_type adc_codes;
    amc_cfg_type active_cfg;
    int error_cnt = 0;
    int n_tests = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    amc_ctrl #(.SETUP_CYCLES(200)) i_amc_ctrl (
        .clk, .nrst, .oversample_select_bit0(os[0]), .oversample_select_bit1(os[1]),
        .oversample_select_bit2(os[2]), .interface_choice_input, .reset_pin,
        .serial_config_input, .serial_clock, .chip_select_n, .write_strobe_n,
        .parallel_bus_lines, .conversion_trigger, .adc_codes, .active_cfg, .soft_mode,
        .serial_mode, .setup_done, .busy, .read_data, .read_valid, .res_valid, .res_ready,
        .res_data
    );
    amc_host_model i_amc_host_model (
        .clk, .serial_config_input, .serial_clock, .chip_select_n, .write_strobe_n,
        .parallel_bus_lines, .conversion_trigger, .read_data, .read_valid, .res_valid,
        .res_data, .res_ready
    );
    // verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // compare one value
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // a wait that ran out
    task automatic hang(input string what);
        error_cnt++;
        $display("unexpected %s: expected 1 seen 0", what);
        complete_run();
    endtask
    // wait for the setup delay to run out
    task automatic wait_setup;
        int n;
        n = 0;
        while (setup_done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) hang("setup_done");
    endtask
    // follow one conversion, then drain all words
    task automatic drain_run(input logic [3:0] c);
        int n;
        logic [15:0] d;
        logic ok;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20) hang("busy");
        n = 0;
        while (busy === 1'b1 && n < 90000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 90000) hang("idle");
        check("conversion time", 16'h0001, 16'(n >= (CONV_CYC << c) && n < (CONV_CYC << c) + 40));
        for (int i = 0; i < 8; i++) begin
            i_amc_host_model.take(d, ok);
            check("result word", adc_codes[i], ok ? d : 16'hFFFF);
        end
        check("fifo empty", 16'h0000, res_valid);
    endtask
    // main sequence
    initial begin
        for (int i = 0; i < 8; i++) adc_codes[i] = 16'hC0D0 + 16'(i);
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        i_amc_host_model.trig();
        check("early busy", 16'h0000, busy);
        check("soft mode", 16'h0000, soft_mode);
        check("serial mode", 16'h0000, serial_mode);
        check("hw ratio", 16'h0003, active_cfg.osr_code);
        os = 3'h7;
        repeat (10) @(negedge clk);
        check("latched mode", 16'h0000, soft_mode);
        wait_setup();
        i_amc_host_model.pwrite({1'b0, ADDR_COMP, 8'h5A}, 1'b0);
        check("hw comp", 16'h0000, active_cfg.comp_en);
        i_amc_host_model.trig();
        drain_run(4'h3);
        $display("hardware test done");
        nrst = 1'b0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        wait_setup();
        check("soft mode", 16'h0001, soft_mode);
        os = 3'h3;
        i_amc_host_model.pwrite({1'b0, ADDR_CFG, 8'h01}, 1'b0);
        check("par ratio", 16'h0001, active_cfg.osr_code);
        i_amc_host_model.pwrite({1'b0, ADDR_CFG, 8'h05}, 1'b1);
        check("tied ratio", 16'h0001, active_cfg.osr_code);
        drain_run(4'h1);
        i_amc_host_model.frame({1'b0, ADDR_CFG, 8'h02}, got, rd);
        check("wrong port", 16'h0001, active_cfg.osr_code);
        interface_choice_input = 1'b1;
        repeat (6) @(negedge clk);
        check("serial mode", 16'h0001, serial_mode);
        for (int k = 0; k < 3; k++) begin
            i_amc_host_model.frame({1'b0, ADDR_CFG, 2'h0, 2'(k), 4'h7}, got, rd);
            check("lines", 16'(k), active_cfg.dout_lines);
        end
        check("sw ratio", 16'h0007, active_cfg.osr_code);
        i_amc_host_model.frame({1'b0, ADDR_RANGE_LO, 8'h00}, got, rd);
        check("ranges", {RANGE_RST[15:8], 8'h00}, active_cfg.ranges);
        i_amc_host_model.frame({1'b0, ADDR_COMP, 8'h5A}, got, rd);
        check("comp", 16'h005A, active_cfg.comp_en);
        i_amc_host_model.frame({1'b0, ADDR_DISC, 8'h3C}, got, rd);
        check("disconnect", 16'h003C, active_cfg.disc_en);
        i_amc_host_model.frame({1'b0, ADDR_DIAG, 8'h01}, got, rd);
        check("diag", 16'h0001, active_cfg.diag_en);
        i_amc_host_model.frame({1'b1, ADDR_CFG, 8'h00}, got, rd);
        check("read back", 16'h0127, {7'h00, got, rd});
        i_amc_host_model.frame(16'h0000, got, rd);
        check("low line", 16'h0007, active_cfg.osr_code);
        i_amc_host_model.trig();
        drain_run(4'h7);
        $display("software test done");
        os = 3'h7;
        reset_pin = 1'b1;
        repeat (20) @(negedge clk);
        reset_pin = 1'b0;
        repeat (30) @(negedge clk);
        check("partial keeps", 16'h0007, active_cfg.osr_code);
        os = 3'h2;
        reset_pin = 1'b1;
        repeat (800) @(negedge clk);
        reset_pin = 1'b0;
        repeat (30) @(negedge clk);
        check("full mode", 16'h0000, soft_mode);
        check("full ratio", 16'h0002, active_cfg.osr_code);
        check("full setup", 16'h0000, setup_done);
        wait_setup();
        $display("reset test done");
        complete_run();
    end
endmodule
`default_nettype wire
